//--- core/gp8_port.sv
// Eight-bit general-purpose I/O port with APB register access
module gp8_port (
	// Clock and reset
	input wire logic REF_CLK_IN,
	input wire logic RSTN_IN,
	// APB slave
	input wire gp8_pkg::gp8_apb_req_t APB_REQ_IN,
	output gp8_pkg::gp8_apb_rsp_t APB_RSP_OUT,
	// Pins
	input wire logic [7:0] PIN_IN,
	output logic [7:0] PIN_OUT,
	output logic [7:0] PIN_OE_OUT
);
	import gp8_pkg::*;

	// ==========================================
	// Register state
	logic [7:0] direction;
	logic [7:0] latch;
	logic [7:0] next_direction;
	logic [7:0] next_latch;
	logic [31:0] prdata;
	logic [31:0] next_prdata;
	logic pslverr;
	logic next_pslverr;

	logic [7:0] pin_level;
	logic [7:0] readback;
	logic [7:0] drive;
	logic [7:0] oe;
	gp8_sel_t sel;
	logic access;

	// ==========================================
	// Pin synchroniser
	gp8_sync #(
		.WIDTH(GP8_PINS)
	) i_gp8_sync (
		.clk_in(REF_CLK_IN),
		.rstn_in(RSTN_IN),
		.d_in(PIN_IN),
		.q_out(pin_level)
	);

	// ==========================================
	// Pin logic
	gp8_pad #(
		.WIDTH(GP8_PINS)
	) i_gp8_pad (
		.direction_in(direction),
		.latch_in(latch),
		.pin_level_in(pin_level),
		.readback_out(readback),
		.drive_out(drive),
		.oe_out(oe)
	);

	// ==========================================
	// Address decode
	always_comb begin
		if (APB_REQ_IN.paddr == GP8_OFF_DIRECTION) begin
			sel = GP8_SEL_DIRECTION;
		end else if (APB_REQ_IN.paddr == GP8_OFF_LATCH) begin
			sel = GP8_SEL_LATCH;
		end else if (APB_REQ_IN.paddr == GP8_OFF_READBACK) begin
			sel = GP8_SEL_READBACK;
		end else begin
			sel = GP8_SEL_NONE;
		end
	end

	// Zero-wait slave: the access phase completes in its first cycle
	assign access = APB_REQ_IN.psel && APB_REQ_IN.penable;

	// ==========================================
	// Register next values
	always_comb begin
		next_direction = direction;
		next_latch = latch;
		next_prdata = prdata;
		next_pslverr = 1'b0;
		if (APB_REQ_IN.psel && !APB_REQ_IN.penable) begin
			// Read data is prepared in setup so it is stable through access
			case (sel)
				GP8_SEL_DIRECTION: next_prdata = GP8_DIRECTION_READ;
				GP8_SEL_LATCH: next_prdata = {24'h000000, latch};
				GP8_SEL_READBACK: next_prdata = {24'h000000, readback};
				default: next_prdata = GP8_UNMAPPED_READ;
			endcase
			next_pslverr = (sel == GP8_SEL_NONE);
		end
		if (access && APB_REQ_IN.pwrite) begin
			case (sel)
				GP8_SEL_DIRECTION: next_direction = APB_REQ_IN.pwdata[7:0];
				GP8_SEL_LATCH: next_latch = APB_REQ_IN.pwdata[7:0];
				default: next_latch = latch;
			endcase
		end
		if (access) begin
			next_pslverr = (sel == GP8_SEL_NONE);
		end
		if (!RSTN_IN) begin
			next_direction = GP8_RST_DIRECTION;
			next_latch = GP8_RST_LATCH;
			next_prdata = 32'h0000_0000;
			next_pslverr = 1'b0;
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		direction <= next_direction;
		latch <= next_latch;
		prdata <= next_prdata;
		pslverr <= next_pslverr;
	end

	// ==========================================
	// Outputs
	assign APB_RSP_OUT.pready = 1'b1;
	assign APB_RSP_OUT.pslverr = pslverr & access;
	assign APB_RSP_OUT.prdata = prdata;
	assign PIN_OUT = drive;
	assign PIN_OE_OUT = oe;
endmodule

//--- inc/gp8_pkg.sv
// Package for the eight-bit general-purpose I/O port: offsets, resets, carriers
package gp8_pkg;

	// ==========================================
	// Sizes
	localparam int GP8_PINS = 8;
	localparam int GP8_AW = 12;

	// ==========================================
	// Register byte offsets
	localparam logic [11:0] GP8_OFF_DIRECTION = 12'h000;
	localparam logic [11:0] GP8_OFF_LATCH = 12'h004;
	localparam logic [11:0] GP8_OFF_READBACK = 12'h008;

	// ==========================================
	// Reset values
	localparam logic [7:0] GP8_RST_DIRECTION = 8'h00;
	localparam logic [7:0] GP8_RST_LATCH = 8'h00;

	// Value returned for a direction read, deliberately not its contents
	localparam logic [31:0] GP8_DIRECTION_READ = 32'h0000_0000;
	// Value returned for an unmapped read
	localparam logic [31:0] GP8_UNMAPPED_READ = 32'h0000_0000;

	// ==========================================
	// Carriers
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} gp8_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} gp8_apb_rsp_t;

	typedef struct packed {
		logic [7:0] dout;
		logic [7:0] oe;
	} gp8_pad_drive_t;

	typedef enum logic [1:0] {
		GP8_SEL_NONE,
		GP8_SEL_DIRECTION,
		GP8_SEL_LATCH,
		GP8_SEL_READBACK
	} gp8_sel_t;

endpackage

//--- core/gp8_sync.sv
// Two-flop synchroniser for the pin inputs
module gp8_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// Data
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_stage2;

	always_comb begin
		next_stage1 = d_in;
		next_stage2 = stage1;
		if (!rstn_in) begin
			next_stage1 = '0;
			next_stage2 = '0;
		end
	end

	always_ff @(posedge clk_in) begin
		stage1 <= next_stage1;
		stage2 <= next_stage2;
	end

	assign q_out = stage2;
endmodule

//--- core/gp8_pad.sv
// Per-pin drive and readback selection
module gp8_pad #(
	parameter int WIDTH = 8
) (
	// Register state
	input wire logic [WIDTH-1:0] direction_in,
	input wire logic [WIDTH-1:0] latch_in,
	// Synchronised pin levels
	input wire logic [WIDTH-1:0] pin_level_in,
	// Results
	output logic [WIDTH-1:0] readback_out,
	output logic [WIDTH-1:0] drive_out,
	output logic [WIDTH-1:0] oe_out
);
	genvar n;
	generate
		for (n = 0; n < WIDTH; n++) begin : g_pin
			// Bit n of every register belongs to pin n
			assign oe_out[n] = direction_in[n];
			assign drive_out[n] = latch_in[n];
			// Output pins read the latch, input pins read the pin
			assign readback_out[n] = direction_in[n] ? latch_in[n] : pin_level_in[n];
		end
	endgenerate
endmodule

//--- testbench/gp8_port_properties.sv
// Checker of the GPIO port registers and pins
module gp8_port_properties (
	// Clock, reset and bus
	input wire logic REF_CLK_IN,
	input wire logic RSTN_IN,
	input wire gp8_pkg::gp8_apb_req_t APB_REQ_IN,
	input wire gp8_pkg::gp8_apb_rsp_t APB_RSP_OUT,
	// Pins
	input wire logic [7:0] PIN_IN,
	input wire logic [7:0] PIN_OUT,
	input wire logic [7:0] PIN_OE_OUT
);
	timeunit 1ns;
	timeprecision 1ns;
	import gp8_pkg::*;
	logic v, w, ad, al, ar;
	logic [7:0] d, q;
	assign v = APB_REQ_IN.psel & APB_REQ_IN.penable;
	assign w = APB_REQ_IN.pwrite;
	assign d = APB_REQ_IN.pwdata[7:0];
	assign q = APB_RSP_OUT.prdata[7:0];
	assign ad = v & (APB_REQ_IN.paddr == GP8_OFF_DIRECTION);
	assign al = v & (APB_REQ_IN.paddr == GP8_OFF_LATCH);
	assign ar = v & (APB_REQ_IN.paddr == GP8_OFF_READBACK);
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (!RSTN_IN);
	dir_wr_a: assert property (ad && w |=> PIN_OE_OUT == $past(d)) else $error("dir write");
	dir_rd_a: assert property (ad && !w |-> APB_RSP_OUT.prdata == GP8_DIRECTION_READ) else $error("dir read");
	lat_wr_a: assert property (al && w |=> PIN_OUT == $past(d)) else $error("latch write");
	lat_rd_a: assert property (al && !w |-> q == PIN_OUT) else $error("latch read");
	rst_val_a: assert property ($rose(RSTN_IN) |-> (PIN_OUT | PIN_OE_OUT) == 8'h00) else $error("reset");
	ro_wr_a: assert property (ar && w |=> $stable(PIN_OUT) && $stable(PIN_OE_OUT)) else $error("ro write");
	rb_out_a: assert property (ar && !w |-> (q & PIN_OE_OUT) == (PIN_OUT & PIN_OE_OUT)) else $error("rb out");
	rb_in_a: assert property ($stable(PIN_IN) [*4] ##0 (ar && !w) |-> ((q ^ PIN_IN) & ~PIN_OE_OUT) == 8'h00)
		else $error("rb in");
	cover property (ar && w);
	cover property (ar && !w);
	cover property (v && !(ad | al | ar));
endmodule

//--- testbench/gp8_pin_model.sv
// External pin model: pads follow the port where driven
module gp8_pin_model (
	input wire logic [7:0] drive_in,
	input wire logic [7:0] oe_in,
	input wire logic [7:0] board_in,
	output logic [7:0] pad_out
);
	timeunit 1ns;
	timeprecision 1ns;
	assign pad_out = (oe_in & drive_in) | (~oe_in & board_in);
endmodule

//--- testbench/tb_gp8_port.sv
// Testbench of the eight-bit GPIO port
module tb_gp8_port;
	timeunit 1ns;
	timeprecision 1ns;
	import gp8_pkg::*;
	logic clk, rstn;
	gp8_apb_req_t req;
	gp8_apb_rsp_t rsp;
	logic [7:0] pin, pout, poe, board;
	logic [31:0] r;
	logic e;
	int mismatches, comparisons, cyc;
	gp8_port i_gp8_port (.REF_CLK_IN(clk), .RSTN_IN(rstn), .APB_REQ_IN(req), .APB_RSP_OUT(rsp),
		.PIN_IN(pin), .PIN_OUT(pout), .PIN_OE_OUT(poe));
	gp8_pin_model i_gp8_pin_model (.drive_in(pout), .oe_in(poe), .board_in(board), .pad_out(pin));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	// One APB transfer, then an idle cycle
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		do @(posedge clk); while (rsp.pready !== 1'b1);
		r = rsp.prdata;
		e = rsp.pslverr;
		req <= '0;
		@(posedge clk);
	endtask
	task automatic stop_test;
		$display("%0d compares %0d mismatches", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		if (++cyc == 2000) begin
			mismatches++;
			stop_test();
		end
	end
	initial begin
		req = '0;
		rstn = 1'b0;
		board = 8'h0f;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk(poe, 32'h0);
		xfer(1'b0, GP8_OFF_LATCH, 32'h0);
		chk(r, 32'h0);
		for (int i = 0; i < 8; i++) begin
			xfer(1'b1, GP8_OFF_DIRECTION, 32'h1 << i);
			chk(poe, 32'h1 << i);
		end
		$display("reset and walk done");
		xfer(1'b1, GP8_OFF_DIRECTION, 32'ha5);
		xfer(1'b0, GP8_OFF_DIRECTION, 32'h0);
		chk(r, GP8_DIRECTION_READ);
		xfer(1'b1, GP8_OFF_LATCH, 32'h3c);
		chk(pout, 32'h3c);
		xfer(1'b0, GP8_OFF_READBACK, 32'h0);
		chk(r, 32'h2e);
		chk(e, 32'h0);
		board <= 8'hf0;
		repeat (4) @(posedge clk);
		xfer(1'b0, GP8_OFF_READBACK, 32'h0);
		chk(r, 32'h74);
		xfer(1'b1, GP8_OFF_READBACK, 32'hff);
		chk(pout, 32'h3c);
		chk(poe, 32'ha5);
		chk(e, 32'h0);
		xfer(1'b0, 12'h00c, 32'h0);
		chk(r, GP8_UNMAPPED_READ);
		chk(e, 32'h1);
		$display("register tests done");
		stop_test();
	end
endmodule

bind gp8_port gp8_port_properties i_gp8_port_properties (.REF_CLK_IN, .RSTN_IN, .APB_REQ_IN, .APB_RSP_OUT,
	.PIN_IN, .PIN_OUT, .PIN_OE_OUT);
